/* File: rtl/aisx_core.sv */
// execution unit for an accumulator instruction subset, with register port
`include "aisx_map.svh"
module aisx_core
   import aisx_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   // instruction issue
   input wire logic instr_valid,
   input wire aisx_instr_t instr,
   output logic instr_ready,
   output logic instr_done,
   // stack
   input wire logic [12:0] stack_top_entry,
   output logic stack_pop,
   // watchdog and sleep
   output logic watchdog_clear,
   output logic prescaler_clear,
   output logic osc_halt,
   // register port
   input wire aisx_bus_t bus,
   output logic [7:0] bus_rdata,
   // state view
   output logic [12:0] pc_out,
   output logic [7:0] acc_out
);
   aisx_state_t s_reg, s_next;
   logic pop_next, wclr_next, pop_reg, wclr_reg;
   logic [7:0] opnd, res;
   logic [8:0] sum;
   logic file_hit;
   logic [3:0] fidx;
   localparam logic [7:0] rst_status = `AISX_RST_STATUS;

   function automatic logic [8:0] add8(input logic [7:0] a, input logic [7:0] b);
      add8 = {1'b0, a} + {1'b0, b};
   endfunction
   function automatic logic half_carry(input logic [7:0] a, input logic [7:0] b);
      logic [4:0] t;
      t = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      half_carry = t[4];
   endfunction
   function automatic logic in_file(input logic [6:0] a);
      in_file = (a >= `AISX_OFF_FILE_LO) &&
                (a < (`AISX_OFF_FILE_LO + 7'(`AISX_FILE_DEPTH)));
   endfunction
   function automatic logic [3:0] file_idx(input logic [6:0] a);
      logic [6:0] d;
      d = a - `AISX_OFF_FILE_LO;
      file_idx = d[3:0];
   endfunction

   assign instr_ready = (s_reg.fsm == AISX_RUN) && clk_en;
   assign instr_done = s_reg.done;
   assign stack_pop = pop_reg;
   assign watchdog_clear = wclr_reg;
   assign prescaler_clear = wclr_reg;
   assign osc_halt = (s_reg.fsm == AISX_SLEEP);
   assign bus_rdata = s_reg.rdata;
   assign pc_out = s_reg.pc;
   assign acc_out = s_reg.acc;

   always_comb begin
      s_next = s_reg;
      pop_next = 1'b0;
      wclr_next = 1'b0;
      s_next.done = 1'b0;
      file_hit = in_file(instr.faddr);
      fidx = file_idx(instr.faddr);
      opnd = file_hit ? s_reg.file[fidx] : 8'h00;
      sum = 9'h000;
      res = 8'h00;
      // register port: reads answer one cycle later
      if (bus.rd) begin
         unique case (bus.addr)
            `AISX_OFF_ACC: s_next.rdata = s_reg.acc;
            `AISX_OFF_STATUS: s_next.rdata = {2'h0, s_reg.fsm == AISX_SLEEP, s_reg.to,
                                              s_reg.pd, s_reg.z, s_reg.dc, s_reg.c};
            `AISX_OFF_CTRL: s_next.rdata = 8'h00;
            default: s_next.rdata = in_file(bus.addr) ? s_reg.file[file_idx(bus.addr)]
                                                       : 8'h00;
         endcase
      end
      if (bus.wr) begin
         if (bus.addr == `AISX_OFF_ACC) begin
            s_next.acc = bus.wdata;
         end else if (bus.addr == `AISX_OFF_CTRL && bus.wdata[`AISX_CTRL_WAKE]
                      && s_reg.fsm == AISX_SLEEP) begin
            s_next.fsm = AISX_RUN;
         end else if (in_file(bus.addr)) begin
            s_next.file[file_idx(bus.addr)] = bus.wdata;
         end
      end
      unique case (s_reg.fsm)
         AISX_RUN: begin
            if (instr_valid) begin
               s_next.done = 1'b1;
               s_next.pc = s_reg.pc + 13'h0001;
               unique case (instr.op)
                  AISX_OP_ADD_LIT: begin
                     sum = add8(s_reg.acc, instr.lit);
                     s_next.acc = sum[7:0];
                     s_next.c = sum[8];
                     s_next.dc = half_carry(s_reg.acc, instr.lit);
                     s_next.z = (sum[7:0] == 8'h00);
                  end
                  AISX_OP_ADD_REG: begin
                     sum = add8(s_reg.acc, opnd);
                     res = sum[7:0];
                     s_next.c = sum[8];
                     s_next.dc = half_carry(s_reg.acc, opnd);
                     s_next.z = (res == 8'h00);
                  end
                  AISX_OP_AND_REG: begin
                     res = s_reg.acc & opnd;
                     s_next.z = (res == 8'h00);
                  end
                  AISX_OP_AND_LIT: begin
                     s_next.acc = s_reg.acc & instr.lit;
                     s_next.z = ((s_reg.acc & instr.lit) == 8'h00);
                  end
                  AISX_OP_BIT_CLR: begin
                     if (file_hit) s_next.file[fidx][instr.bitsel] = 1'b0;
                  end
                  AISX_OP_BIT_SET: begin
                     if (file_hit) s_next.file[fidx][instr.bitsel] = 1'b1;
                  end
                  AISX_OP_ROT_LEFT: begin
                     res = {opnd[6:0], s_reg.c};
                     s_next.c = opnd[7];
                  end
                  AISX_OP_ROT_RIGHT: begin
                     res = {s_reg.c, opnd[7:1]};
                     s_next.c = opnd[0];
                  end
                  AISX_OP_RET_LIT: begin
                     s_next.acc = instr.lit;
                     s_next.pc = stack_top_entry;
                     pop_next = 1'b1;
                     s_next.done = 1'b0;
                     s_next.fsm = AISX_RET2;
                  end
                  AISX_OP_RETURN: begin
                     s_next.pc = stack_top_entry;
                     pop_next = 1'b1;
                     s_next.done = 1'b0;
                     s_next.fsm = AISX_RET2;
                  end
                  AISX_OP_SLEEP: begin
                     s_next.pd = 1'b0;
                     s_next.to = 1'b1;
                     wclr_next = 1'b1;
                     s_next.fsm = AISX_SLEEP;
                  end
                  default: ;
               endcase
               if (instr.op inside {AISX_OP_ADD_REG, AISX_OP_AND_REG,
                                    AISX_OP_ROT_LEFT, AISX_OP_ROT_RIGHT}) begin
                  if (!instr.dest) begin
                     s_next.acc = res;
                  end else if (file_hit) begin
                     s_next.file[fidx] = res;
                  end
               end
            end
         end
         AISX_RET2: begin
            s_next.done = 1'b1;
            s_next.fsm = AISX_RUN;
         end
         AISX_SLEEP: ;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s_reg.fsm <= AISX_RUN;
         s_reg.acc <= `AISX_RST_ACC;
         s_reg.c <= rst_status[`AISX_BIT_C];
         s_reg.dc <= rst_status[`AISX_BIT_DC];
         s_reg.z <= rst_status[`AISX_BIT_Z];
         s_reg.pd <= rst_status[`AISX_BIT_PD];
         s_reg.to <= rst_status[`AISX_BIT_TO];
         s_reg.pc <= `AISX_RST_PC;
         s_reg.rdata <= 8'h00;
         s_reg.file <= '0;
         s_reg.done <= 1'b0;
         pop_reg <= 1'b0;
         wclr_reg <= 1'b0;
      end else if (clk_en) begin
         s_reg <= s_next;
         pop_reg <= pop_next;
         wclr_reg <= wclr_next;
      end
   end

   // checks
   property p_add_lit;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op == AISX_OP_ADD_LIT |=>
      {s_reg.c, acc_out} == {1'b0, $past(s_reg.acc)} + {1'b0, $past(instr.lit)} &&
      s_reg.z == (acc_out == 8'h00);
   endproperty
   a_add_lit: assert property (p_add_lit) else $error("add literal wrong");
   property p_and_lit;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op == AISX_OP_AND_LIT |=>
      acc_out == ($past(s_reg.acc) & $past(instr.lit)) && s_reg.c == $past(s_reg.c) &&
      s_reg.z == (acc_out == 8'h00);
   endproperty
   a_and_lit: assert property (p_and_lit) else $error("and literal wrong");
   property p_bits_keep_flags;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op inside {AISX_OP_BIT_CLR, AISX_OP_BIT_SET}
      |=> {s_reg.c, s_reg.dc, s_reg.z} == $past({s_reg.c, s_reg.dc, s_reg.z});
   endproperty
   a_bits_keep_flags: assert property (p_bits_keep_flags) else $error("bit op flags");
   property p_rot_left_c;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op == AISX_OP_ROT_LEFT && in_file(instr.faddr)
      |=> s_reg.c == $past(opnd[7]);
   endproperty
   a_rot_left_c: assert property (p_rot_left_c) else $error("rotate left carry");
   property p_ret_two;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op == AISX_OP_RETURN
      |=> !instr_done && pc_out == $past(stack_top_entry) ##1 (instr_done || !$past(clk_en));
   endproperty
   a_ret_two: assert property (p_ret_two) else $error("return timing");
   property p_sleep_flags;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op == AISX_OP_SLEEP
      |=> !s_reg.pd && s_reg.to && watchdog_clear && prescaler_clear && osc_halt;
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) else $error("sleep effects");
   property p_pc_step;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid &&
      !(instr.op inside {AISX_OP_RETURN, AISX_OP_RET_LIT}) |=> pc_out == $past(pc_out) + 13'h0001;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
   property p_halt_hold;
      @(posedge clk_sys) disable iff (reset)
      osc_halt && !(bus.wr && bus.addr == `AISX_OFF_CTRL) |=> osc_halt && !instr_ready;
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("sleep left");

   // operand checks only where the address lands in the file
   property p_and_reg;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op == AISX_OP_AND_REG && !instr.dest &&
      in_file(instr.faddr) |=> acc_out == ($past(s_reg.acc) & $past(opnd)) &&
      s_reg.z == (acc_out == 8'h00) && {s_reg.c, s_reg.dc} == $past({s_reg.c, s_reg.dc});
   endproperty
   a_and_reg: assert property (p_and_reg) else $error("and register wrong");

   property p_add_reg;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op == AISX_OP_ADD_REG &&
      in_file(instr.faddr)
      |=> {s_reg.c, ($past(instr.dest) ? s_reg.file[$past(fidx)] : acc_out)} ==
      {1'b0, $past(s_reg.acc)} + {1'b0, $past(opnd)};
   endproperty
   a_add_reg: assert property (p_add_reg) else $error("add register wrong");

   property p_bit_clr;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op == AISX_OP_BIT_CLR &&
      in_file(instr.faddr) |=> s_reg.file[$past(fidx)][$past(instr.bitsel)] == 1'b0;
   endproperty
   a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");

   property p_bit_set;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op == AISX_OP_BIT_SET &&
      in_file(instr.faddr) |=> s_reg.file[$past(fidx)][$past(instr.bitsel)] == 1'b1;
   endproperty
   a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

   property p_rot_right;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op == AISX_OP_ROT_RIGHT &&
      in_file(instr.faddr) |=> s_reg.c == $past(opnd[0]) &&
      ($past(instr.dest) || acc_out == {$past(s_reg.c), $past(opnd[7:1])});
   endproperty
   a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");

   property p_rot_flags;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid &&
      instr.op inside {AISX_OP_ROT_LEFT, AISX_OP_ROT_RIGHT} |=>
      {s_reg.dc, s_reg.z} == $past({s_reg.dc, s_reg.z});
   endproperty
   a_rot_flags: assert property (p_rot_flags) else $error("rotate flags");

   property p_ret_lit;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op == AISX_OP_RET_LIT |=>
      acc_out == $past(instr.lit) && pc_out == $past(stack_top_entry) && stack_pop &&
      !instr_ready && !instr_done;
   endproperty
   a_ret_lit: assert property (p_ret_lit) else $error("return literal wrong");

   property p_ret_flags;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid && instr.op inside {AISX_OP_RETURN, AISX_OP_RET_LIT}
      |=> {s_reg.c, s_reg.dc, s_reg.z} == $past({s_reg.c, s_reg.dc, s_reg.z});
   endproperty
   a_ret_flags: assert property (p_ret_flags) else $error("return flags");

   property p_pop_once;
      @(posedge clk_sys) disable iff (reset)
      stack_pop && clk_en |=> !stack_pop;
   endproperty
   a_pop_once: assert property (p_pop_once) else $error("pop too long");

   property p_done_single;
      @(posedge clk_sys) disable iff (reset)
      clk_en && instr_ready && instr_valid &&
      !(instr.op inside {AISX_OP_RETURN, AISX_OP_RET_LIT}) |=> instr_done;
   endproperty
   a_done_single: assert property (p_done_single) else $error("done missing");

   property p_sleep_pc;
      @(posedge clk_sys) disable iff (reset)
      osc_halt && clk_en |=> pc_out == $past(pc_out);
   endproperty
   a_sleep_pc: assert property (p_sleep_pc) else $error("pc moved in sleep");

   c_sleep: cover property (@(posedge clk_sys) disable iff (reset) osc_halt);
   c_wake: cover property (@(posedge clk_sys) disable iff (reset) $fell(osc_halt));
   c_half_carry: cover property (@(posedge clk_sys) disable iff (reset) $rose(s_reg.dc));
   c_ret: cover property (@(posedge clk_sys) disable iff (reset) stack_pop);
   c_carry: cover property (@(posedge clk_sys) disable iff (reset) $rose(s_reg.c));
endmodule

/* File: rtl/aisx_map.svh */
// register offsets, field positions, reset values and timing counts for the execution unit
`ifndef AISX_MAP_SVH
`define AISX_MAP_SVH
`define AISX_ADDR_W 7
`define AISX_OFF_ACC 7'h00
`define AISX_OFF_STATUS 7'h01
`define AISX_OFF_CTRL 7'h02
`define AISX_OFF_FILE_LO 7'h10
`define AISX_FILE_DEPTH 16
`define AISX_FILE_IDX_W 4
`define AISX_BIT_C 0
`define AISX_BIT_DC 1
`define AISX_BIT_Z 2
`define AISX_BIT_PD 3
`define AISX_BIT_TO 4
`define AISX_BIT_SLEEP 5
`define AISX_CTRL_WAKE 0
`define AISX_RST_ACC 8'h00
`define AISX_RST_STATUS 8'h18
`define AISX_RST_PC 13'h0000
`define AISX_RET_CYCLES 2'h2
`define AISX_WDT_CLEAR 8'h00
`endif

/* File: rtl/aisx_pkg.sv */
// types shared by the instruction execution unit
package aisx_pkg;
   typedef enum logic [3:0] {
      AISX_OP_NOP, AISX_OP_ADD_LIT, AISX_OP_AND_REG, AISX_OP_ADD_REG, AISX_OP_AND_LIT,
      AISX_OP_BIT_CLR, AISX_OP_BIT_SET, AISX_OP_ROT_LEFT, AISX_OP_ROT_RIGHT,
      AISX_OP_RET_LIT, AISX_OP_RETURN, AISX_OP_SLEEP
   } aisx_op_t;
   typedef struct packed {
      aisx_op_t op;
      logic [6:0] faddr;
      logic dest;
      logic [2:0] bitsel;
      logic [7:0] lit;
   } aisx_instr_t;
   typedef enum logic [1:0] {AISX_RUN, AISX_RET2, AISX_SLEEP} aisx_fsm_t;
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } aisx_bus_t;
   typedef struct packed {
      aisx_fsm_t fsm;
      logic [7:0] acc;
      logic c;
      logic dc;
      logic z;
      logic pd;
      logic to;
      logic [12:0] pc;
      logic [7:0] rdata;
      logic [15:0][7:0] file;
      logic done;
   } aisx_state_t;
endpackage

/* File: tb/testbench.sv */
// self-checking bench for the accumulator instruction execution unit
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import aisx_pkg::*;
   typedef struct packed {
      aisx_op_t op;
      logic d;
      logic [2:0] b;
      logic [7:0] k, acc, fv;
      logic [2:0] fl;
   } aisx_row_t;
   localparam logic [6:0] FA = 7'h10;
   logic clk_sys, reset, clk_en, instr_valid, instr_ready, instr_done, stack_pop;
   logic watchdog_clear, prescaler_clear, osc_halt;
   aisx_instr_t instr;
   aisx_bus_t bus;
   logic [12:0] stack_top_entry, pc_out, pc_exp;
   logic [7:0] bus_rdata, acc_out, rd;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   // flags column is {z, dc, c}; the file byte at 10h starts as 3C
   aisx_row_t rows [15] = '{
      '{AISX_OP_ADD_LIT, 1'b0, 3'h0, 8'h0F, 8'h0F, 8'h3C, 3'h0},
      '{AISX_OP_ADD_LIT, 1'b0, 3'h0, 8'hF1, 8'h00, 8'h3C, 3'h7},
      '{AISX_OP_ADD_LIT, 1'b0, 3'h0, 8'h3C, 8'h3C, 8'h3C, 3'h0},
      '{AISX_OP_ADD_REG, 1'b1, 3'h0, 8'h00, 8'h3C, 8'h78, 3'h2},
      '{AISX_OP_AND_REG, 1'b0, 3'h0, 8'h00, 8'h38, 8'h78, 3'h2},
      '{AISX_OP_AND_LIT, 1'b0, 3'h0, 8'hC7, 8'h00, 8'h78, 3'h6},
      '{AISX_OP_ADD_REG, 1'b0, 3'h0, 8'h00, 8'h78, 8'h78, 3'h0},
      '{AISX_OP_ROT_LEFT, 1'b1, 3'h0, 8'h00, 8'h78, 8'hF0, 3'h0},
      '{AISX_OP_ROT_LEFT, 1'b0, 3'h0, 8'h00, 8'hE0, 8'hF0, 3'h1},
      '{AISX_OP_ROT_RIGHT, 1'b1, 3'h0, 8'h00, 8'hE0, 8'hF8, 3'h0},
      '{AISX_OP_ADD_LIT, 1'b0, 3'h0, 8'h20, 8'h00, 8'hF8, 3'h5},
      '{AISX_OP_BIT_CLR, 1'b0, 3'h7, 8'h00, 8'h00, 8'h78, 3'h5},
      '{AISX_OP_BIT_SET, 1'b0, 3'h0, 8'h00, 8'h00, 8'h79, 3'h5},
      '{AISX_OP_ROT_RIGHT, 1'b0, 3'h0, 8'h00, 8'hBC, 8'h79, 3'h5},
      '{AISX_OP_AND_REG, 1'b1, 3'h0, 8'h00, 8'hBC, 8'h38, 3'h1}
   };

   aisx_core uut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .instr_valid(instr_valid),
      .instr(instr), .instr_ready(instr_ready), .instr_done(instr_done),
      .stack_top_entry(stack_top_entry), .stack_pop(stack_pop),
      .watchdog_clear(watchdog_clear), .prescaler_clear(prescaler_clear),
      .osc_halt(osc_halt), .bus(bus), .bus_rdata(bus_rdata), .pc_out(pc_out),
      .acc_out(acc_out));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic tally_and_finish;
      if (mismatches == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // hang guard: the whole sequence needs well under 400 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         tally_and_finish;
      end
   end

   task automatic check(input string nm, input logic [12:0] e, input logic [12:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic bus_wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      bus <= '{a, v, 1'b1, 1'b0};
      @(posedge clk_sys);
      bus <= '0;
   endtask

   // read data stands from the cycle after the strobe until the next read
   task automatic bus_rd(input logic [6:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys);
      bus <= '0;
      #1 v = bus_rdata;
   endtask

   task automatic exec(input aisx_op_t op, input logic d, input logic [2:0] b,
                       input logic [7:0] k);
      @(posedge clk_sys);
      instr_valid <= 1'b1;
      instr <= '{op, FA, d, b, k};
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      #1;
   endtask

   task automatic ret_chk(input aisx_op_t op, input logic [12:0] top, input logic [7:0] a);
      stack_top_entry <= top;
      exec(op, 1'b0, 3'h0, 8'hA5);
      check("pc", top, pc_out);
      check("acc", a, acc_out);
      check("pop", 1, stack_pop);
      check("ready", 0, instr_ready);
      check("done", 0, instr_done);
      @(posedge clk_sys);
      #1 check("done", 1, instr_done);
      check("pop", 0, stack_pop);
      bus_rd(7'h01, rd);
      check("status", 8'h19, rd);
   endtask

   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      instr_valid = 1'b0;
      instr = '0;
      bus = '0;
      stack_top_entry = '0;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      #1 check("acc", 0, acc_out);
      check("pc", 0, pc_out);
      bus_rd(7'h01, rd);
      check("status", 8'h18, rd);
      bus_wr(FA, 8'h3C);
      pc_exp = pc_out;
      foreach (rows[i]) begin
         exec(rows[i].op, rows[i].d, rows[i].b, rows[i].k);
         pc_exp = pc_exp + 13'h0001;
         check("done", 1, instr_done);
         check("pc", pc_exp, pc_out);
         check("acc", rows[i].acc, acc_out);
         bus_rd(FA, rd);
         check("file", rows[i].fv, rd);
         bus_rd(7'h01, rd);
         check("status", {5'h03, rows[i].fl}, rd);
      end
      // a frozen clock enable must leave the instruction untaken
      @(posedge clk_sys);
      clk_en <= 1'b0;
      exec(AISX_OP_ADD_LIT, 1'b0, 3'h0, 8'h11);
      check("frozen acc", 8'hBC, acc_out);
      check("frozen pc", pc_exp, pc_out);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      ret_chk(AISX_OP_RETURN, 13'h1234, 8'hBC);
      ret_chk(AISX_OP_RET_LIT, 13'h0FED, 8'hA5);
      exec(AISX_OP_SLEEP, 1'b0, 3'h0, 8'h00);
      check("wdt clear", 1, watchdog_clear);
      check("prescaler clear", 1, prescaler_clear);
      check("halt", 1, osc_halt);
      check("ready", 0, instr_ready);
      bus_rd(7'h01, rd);
      check("status", 8'h31, rd);
      check("wdt clear", 0, watchdog_clear);
      check("halt", 1, osc_halt);
      bus_wr(7'h02, 8'h01);
      @(posedge clk_sys);
      #1 check("halt", 0, osc_halt);
      exec(AISX_OP_AND_LIT, 1'b0, 3'h0, 8'h0F);
      check("acc", 8'h05, acc_out);
      // reset again in mid-run: state returns to its reset values
      @(posedge clk_sys);
      reset <= 1'b1;
      @(posedge clk_sys);
      reset <= 1'b0;
      #1 check("acc", 0, acc_out);
      check("pc", 0, pc_out);
      check("done", 0, instr_done);
      bus_rd(7'h01, rd);
      check("status", 8'h18, rd);
      bus_rd(FA, rd);
      check("file", 8'h00, rd);
      tally_and_finish;
   end
endmodule
